// ==== uec_engine_ctrl.sv ====
// Control, configuration and endpoint command logic of the serial interface engine
// Summary of operation
// - DMA inhibit bit stops engine DMA transfers while set.
// - Force acknowledge bit makes receive always answer with acknowledge.
// - Force tag bit marks next transmit FIFO byte as last payload byte.
// - Force overflow bit raises receive overflow and flushes receive FIFO.
// - Force abort bit corrupts outgoing packet with a bit-stuff error.
// - Force end bit ends current engine transaction.
// - Control one bit 1 shows receive last tag, bit 0 transmit success.
// - Engine reset bit resets engine; frame reset clears low and high bits 2:0.
// - Extended frame bits 7:3 zero when off, count bit 2 falls when on.
// - Suspend bit forces engine into bus suspend; firmware decides when.
// - Resume bit drives resume signaling on the bus.
// - Resume seen in suspend sets status bit and pulses an interrupt.
// - SE0 for 32 bit times sets bus reset status and pulses an interrupt.
// - Busy-on-setup makes control endpoint busy on setup in enabled directions.
// - Two-bit limit picks 1023, 240 or 496 byte isochronous payload.
// - Command bit 7 selects transmit or receive direction bits.
// - Codes 0 to 3 set disabled, stall, normal or NAK handshake.
// - Codes 4 to 7 clear or set toggle, clear or set iso.
// - Command write changes one endpoint selected by bits 3:0 only.
// - Marked endpoints give no response to setup tokens.
`include "uec_defines.svh"
`default_nettype none
module uec_engine_ctrl
  import uec_pkg::*;
#(
  parameter int EP_NUM = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`UEC_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire uec_eng_t eng_in,
  output uec_force_t force_out,
  output logic engine_reset_out,
  output logic engine_suspend_out,
  output logic engine_send_resume_out,
  output logic full_speed_enable_out,
  output logic setup_ignore_out,
  output logic [10:0] iso_limit_bytes,
  output uec_ep_t [EP_NUM-1:0] ep_ctrl_out,
  output logic resume_irq,
  output logic bus_reset_irq
);
  logic [7:0] ctrl1_r;
  logic [5:0] config_r;
  logic [2:0] ctrl2_r;
  logic [7:0] epcmd_r;
  logic [7:0] nctl_hi_r;
  logic [7:0] nctl_lo_r;
  logic eng_rst_r;
  logic resume_seen_r;
  logic bus_reset_r;
  logic [7:0] se0_cnt_r;
  logic [7:0] se0_cnt_nxt;
  logic [15:0] frame_r;
  logic [15:0] frame_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  uec_ep_t [EP_NUM-1:0] ep_r;

  wire wr_ctrl1 = bus_wr && bus_addr == `UEC_OFF_CTRL1;
  wire wr_config = bus_wr && bus_addr == `UEC_OFF_CONFIG;
  wire wr_ctrl2 = bus_wr && bus_addr == `UEC_OFF_CTRL2;
  wire wr_epcmd = bus_wr && bus_addr == `UEC_OFF_EPCMD;
  wire wr_nctl_hi = bus_wr && bus_addr == `UEC_OFF_NCTL_HI;
  wire wr_nctl_lo = bus_wr && bus_addr == `UEC_OFF_NCTL_LO;
  wire eng_rst_now = wr_config && bus_wdata[`UEC_CFG_ENG_RST];
  wire frm_rst_now = wr_config && bus_wdata[`UEC_CFG_FRM_RST];
  // Config bits 7:2 sit in config_r[5:0], so every field index drops by two
  wire extfrm_en = config_r[`UEC_CFG_EXTFRM - 2];
  wire [3:0] cmd_ep = bus_wdata[3:0];
  wire cmd_tx = bus_wdata[`UEC_EPC_TX_BIT];
  wire [2:0] cmd_code = bus_wdata[6:4];
  wire [15:0] nctl_all = {nctl_hi_r, nctl_lo_r};
  wire se0_long = se0_cnt_r >= 8'(`UEC_BUS_RST_CYC);
  wire ep_is_ctrl = !nctl_all[eng_in.endpoint];

  // Control one bits 7:2 feed the engine side ports; force bits go straight to the engine
  assign force_out.dma_inhibit = ctrl1_r[7];
  assign force_out.force_ack = ctrl1_r[6];
  assign force_out.force_last_tag = ctrl1_r[5];
  assign force_out.force_overflow = ctrl1_r[4];
  assign force_out.force_abort = ctrl1_r[3];
  assign force_out.force_end_of_transaction = ctrl1_r[2];
  assign full_speed_enable_out = config_r[5];
  assign engine_reset_out = eng_rst_r;
  assign engine_suspend_out = config_r[`UEC_CFG_SUSP - 2];
  assign engine_send_resume_out = config_r[`UEC_CFG_RESUME - 2];
  assign setup_ignore_out = eng_in.setup_seen && !ep_is_ctrl;
  assign ep_ctrl_out = ep_r;
  assign bus_rdata = rdata_r;

  // Limit code 01 and 11 share the short payload
  always_comb begin
    unique case (ctrl2_r[1:0])
      2'b00: iso_limit_bytes = `UEC_ISO_1023;
      2'b10: iso_limit_bytes = `UEC_ISO_496;
      default: iso_limit_bytes = `UEC_ISO_240;
    endcase
  end

  always_comb begin
    se0_cnt_nxt = se0_cnt_r;
    if (!eng_in.se0) begin
      se0_cnt_nxt = 8'h00;
    end else if (!se0_long) begin
      se0_cnt_nxt = se0_cnt_r + 8'h01;
    end
  end

  // Extended bits follow falls of bit 10; only the high bits keep the width
  always_comb begin
    frame_nxt = frame_r;
    if (eng_in.frame_load) begin
      frame_nxt[10:0] = eng_in.frame_value;
    end else if (eng_in.frame_missed) begin
      frame_nxt[10:0] = frame_r[10:0] + 11'h001;
    end
    if (extfrm_en && frame_r[10] && !frame_nxt[10]) begin
      frame_nxt[15:11] = frame_r[15:11] + 5'h01;
    end
    if (!extfrm_en) begin
      frame_nxt[15:11] = 5'h00;
    end
    if (frm_rst_now) begin
      frame_nxt[10:0] = 11'h000;
    end
  end

  always_comb begin
    unique case (bus_addr)
      `UEC_OFF_CTRL1: rdata_nxt = {ctrl1_r[7:2], eng_in.rx_last_tag, eng_in.tx_success};
      `UEC_OFF_CONFIG: rdata_nxt = {config_r, resume_seen_r, bus_reset_r};
      `UEC_OFF_CTRL2: rdata_nxt = {5'h00, ctrl2_r};
      `UEC_OFF_EPCMD: rdata_nxt = epcmd_r;
      `UEC_OFF_NCTL_HI: rdata_nxt = nctl_hi_r;
      `UEC_OFF_NCTL_LO: rdata_nxt = nctl_lo_r;
      `UEC_OFF_FRAME_LO: rdata_nxt = frame_r[7:0];
      `UEC_OFF_FRAME_HI: rdata_nxt = frame_r[15:8];
      default: rdata_nxt = `UEC_RST_ZERO;
    endcase
    if (bus_addr >= `UEC_OFF_ENDPOINT_CONTROL_BITS_LO && bus_addr <= `UEC_OFF_ENDPOINT_CONTROL_BITS_HI) begin
      rdata_nxt = ep_r[bus_addr[3:0]];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= `UEC_RST_ZERO;
    end else begin
      rdata_r <= bus_rd ? rdata_nxt : `UEC_RST_ZERO;
    end
  end

  // Reset and frame-reset bits are strobes; only the engine reset bit holds, at its reset value of 1 until a config write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_r <= `UEC_RST_ZERO;
      config_r <= 6'(`UEC_RST_CONFIG >> 2);
      ctrl2_r <= 3'h0;
      epcmd_r <= `UEC_RST_ZERO;
      nctl_hi_r <= `UEC_RST_ZERO;
      nctl_lo_r <= `UEC_RST_ZERO;
      eng_rst_r <= 1'b0;
    end else begin
      eng_rst_r <= eng_rst_now;
      if (wr_ctrl1) begin
        ctrl1_r <= {bus_wdata[7:2], 2'b00};
      end
      if (wr_config) begin
        config_r <= {bus_wdata[7], 1'b0, 1'b0, bus_wdata[4:2]};
      end
      if (wr_ctrl2) begin
        ctrl2_r <= bus_wdata[2:0];
      end
      if (wr_epcmd) begin
        epcmd_r <= bus_wdata;
      end
      if (wr_nctl_hi) begin
        nctl_hi_r <= bus_wdata;
      end
      if (wr_nctl_lo) begin
        nctl_lo_r <= bus_wdata;
      end
    end
  end

  // Resume status clears when suspend is off; bus reset status follows the long SE0 level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resume_seen_r <= 1'b0;
      bus_reset_r <= 1'b0;
      se0_cnt_r <= 8'h00;
      frame_r <= 16'h0000;
      resume_irq <= 1'b0;
      bus_reset_irq <= 1'b0;
    end else begin
      se0_cnt_r <= se0_cnt_nxt;
      frame_r <= frame_nxt;
      resume_irq <= eng_in.resume_seen && engine_suspend_out && !resume_seen_r;
      bus_reset_irq <= se0_long && !bus_reset_r;
      if (eng_in.resume_seen && engine_suspend_out) begin
        resume_seen_r <= 1'b1;
      end else if (!engine_suspend_out) begin
        resume_seen_r <= 1'b0;
      end
      bus_reset_r <= se0_long;
    end
  end

  // One command write touches only the selected endpoint and direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ep_r <= '0;
    end else begin
      if (wr_epcmd) begin
        if (cmd_tx) begin
          unique case (cmd_code)
            3'h0: ep_r[cmd_ep].tx.hs <= UEC_HS_OFF;
            3'h1: ep_r[cmd_ep].tx.hs <= UEC_HS_STALL;
            3'h2: ep_r[cmd_ep].tx.hs <= UEC_HS_NORMAL;
            3'h3: ep_r[cmd_ep].tx.hs <= UEC_HS_NAK;
            3'h4: ep_r[cmd_ep].tx.toggle <= 1'b0;
            3'h5: ep_r[cmd_ep].tx.toggle <= 1'b1;
            3'h6: ep_r[cmd_ep].tx.iso <= 1'b0;
            3'h7: ep_r[cmd_ep].tx.iso <= 1'b1;
          endcase
        end else begin
          unique case (cmd_code)
            3'h0: ep_r[cmd_ep].rx.hs <= UEC_HS_OFF;
            3'h1: ep_r[cmd_ep].rx.hs <= UEC_HS_STALL;
            3'h2: ep_r[cmd_ep].rx.hs <= UEC_HS_NORMAL;
            3'h3: ep_r[cmd_ep].rx.hs <= UEC_HS_NAK;
            3'h4: ep_r[cmd_ep].rx.toggle <= 1'b0;
            3'h5: ep_r[cmd_ep].rx.toggle <= 1'b1;
            3'h6: ep_r[cmd_ep].rx.iso <= 1'b0;
            3'h7: ep_r[cmd_ep].rx.iso <= 1'b1;
          endcase
        end
      end else if (eng_in.setup_seen && ctrl2_r[`UEC_CTRL2_BUSY] && ep_is_ctrl) begin
        // Busy means always-NAK; a disabled direction stays disabled
        if (ep_r[eng_in.endpoint].tx.hs != UEC_HS_OFF) begin
          ep_r[eng_in.endpoint].tx.hs <= UEC_HS_NAK;
        end
        if (ep_r[eng_in.endpoint].rx.hs != UEC_HS_OFF) begin
          ep_r[eng_in.endpoint].rx.hs <= UEC_HS_NAK;
        end
      end
    end
  end

  a_force_bits_out: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl1 |=> force_out.dma_inhibit == $past(bus_wdata[7])
      && force_out.force_end_of_transaction == $past(bus_wdata[2]))
    else $error("force bits do not follow control one write");
  a_ctrl1_status_rd: assert property (@(posedge clk) disable iff (!nrst)
    bus_rd && bus_addr == `UEC_OFF_CTRL1 |=> bus_rdata[1:0]
      == $past({eng_in.rx_last_tag, eng_in.tx_success}))
    else $error("control one status bits wrong");
  a_eng_rst_pulse: assert property (@(posedge clk) disable iff (!nrst)
    eng_rst_now |=> engine_reset_out ##1 (!engine_reset_out || $past(eng_rst_now)))
    else $error("engine reset strobe wrong");
  a_ext_frame_zero: assert property (@(posedge clk) disable iff (!nrst)
    !extfrm_en && !$past(extfrm_en) |-> frame_r[15:11] == 5'h00)
    else $error("extended frame bits not zero");
  a_bus_reset_time: assert property (@(posedge clk) disable iff (!nrst)
    !se0_long |=> !bus_reset_r)
    else $error("bus reset seen too early");
  a_bus_reset_irq: assert property (@(posedge clk) disable iff (!nrst)
    $rose(bus_reset_r) |-> bus_reset_irq)
    else $error("bus reset interrupt missing");
  a_iso_limit_map: assert property (@(posedge clk) disable iff (!nrst)
    ctrl2_r[1:0] == 2'b10 |-> iso_limit_bytes == 11'h1f0)
    else $error("iso limit code wrong");
  a_cmd_set_toggle: assert property (@(posedge clk) disable iff (!nrst)
    wr_epcmd && cmd_code == 3'h5 && cmd_tx |=> ep_r[$past(cmd_ep)].tx.toggle)
    else $error("toggle set command failed");
  a_setup_ignore: assert property (@(posedge clk) disable iff (!nrst)
    eng_in.setup_seen && nctl_all[eng_in.endpoint] |-> setup_ignore_out)
    else $error("marked endpoint answered setup");

  // Remaining checks share one clock and one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_resume_in_suspend;
    eng_in.resume_seen && engine_suspend_out && !resume_seen_r;
  endsequence
  sequence s_se0_crosses;
    eng_in.se0 && se0_cnt_r == 8'(`UEC_BUS_RST_CYC - 1);
  endsequence
  sequence s_busy_setup;
    eng_in.setup_seen && ctrl2_r[`UEC_CTRL2_BUSY] && ep_is_ctrl && !wr_epcmd;
  endsequence
  // Frame reset masks the fall, so it is left out here
  sequence s_bit10_falls;
    extfrm_en && !frm_rst_now && frame_r[10] && !frame_nxt[10];
  endsequence
  a_dma_inhibit_wr: assert property (wr_ctrl1 |=>
    force_out.dma_inhibit == $past(bus_wdata[7]))
    else $error("dma inhibit bit wrong");
  a_dma_inhibit_hold: assert property (!wr_ctrl1 |=>
    $stable(force_out))
    else $error("force bits moved without a write");
  a_force_ack_wr: assert property (wr_ctrl1 |=>
    force_out.force_ack == $past(bus_wdata[6]))
    else $error("force acknowledge bit wrong");
  a_force_tag_wr: assert property (wr_ctrl1 |=>
    force_out.force_last_tag == $past(bus_wdata[5]))
    else $error("force tag bit wrong");
  a_force_ovf_wr: assert property (wr_ctrl1 |=>
    force_out.force_overflow == $past(bus_wdata[4]))
    else $error("force overflow bit wrong");
  a_force_abort_wr: assert property (wr_ctrl1 |=>
    force_out.force_abort == $past(bus_wdata[3]))
    else $error("force abort bit wrong");
  a_force_end_of_transaction_wr: assert property (wr_ctrl1 |=>
    force_out.force_end_of_transaction == $past(bus_wdata[2]))
    else $error("force end bit wrong");
  a_eng_rst_quiet: assert property (!eng_rst_now |=>
    !engine_reset_out)
    else $error("engine reset without a write");
  a_frame_rst_low: assert property (frm_rst_now |=>
    frame_r[10:0] == 11'h000)
    else $error("frame reset left count");
  a_ext_frame_step: assert property (s_bit10_falls |=>
    frame_r[15:11] == $past(frame_r[15:11]) + 5'h01)
    else $error("extended frame did not count");
  a_ext_frame_hold: assert property (extfrm_en && !(frame_r[10] && !frame_nxt[10]) |=>
    frame_r[15:11] == $past(frame_r[15:11]))
    else $error("extended frame moved");
  a_suspend_wr: assert property (wr_config |=>
    engine_suspend_out == $past(bus_wdata[`UEC_CFG_SUSP]))
    else $error("suspend bit wrong");
  a_resume_wr: assert property (wr_config |=>
    engine_send_resume_out == $past(bus_wdata[`UEC_CFG_RESUME]))
    else $error("resume drive bit wrong");
  a_full_speed_enable_wr: assert property (wr_config |=>
    full_speed_enable_out == $past(bus_wdata[`UEC_CFG_FULL_SPEED_ENABLE]))
    else $error("full speed bit wrong");
  a_resume_seen_set: assert property (s_resume_in_suspend |=>
    resume_irq && resume_seen_r)
    else $error("resume not flagged");
  a_resume_irq_once: assert property (resume_irq |=>
    !resume_irq)
    else $error("resume interrupt too long");
  a_bus_reset_set: assert property (s_se0_crosses |->
    ##2 bus_reset_r && bus_reset_irq)
    else $error("bus reset not flagged");
  a_se0_count_clear: assert property (!eng_in.se0 |=>
    se0_cnt_r == 8'h00)
    else $error("line reset timer not cleared");
  a_busy_tx_nak: assert property (s_busy_setup ##0 ep_r[eng_in.endpoint].tx.hs != UEC_HS_OFF |=>
    ep_r[$past(eng_in.endpoint)].tx.hs == UEC_HS_NAK)
    else $error("setup did not make endpoint busy");
  a_busy_off_stays: assert property (s_busy_setup ##0 ep_r[eng_in.endpoint].rx.hs == UEC_HS_OFF |=>
    ep_r[$past(eng_in.endpoint)].rx.hs == UEC_HS_OFF)
    else $error("setup woke a disabled direction");
  a_setup_no_busy: assert property (eng_in.setup_seen && !ctrl2_r[`UEC_CTRL2_BUSY] && !wr_epcmd |=>
    ep_r == $past(ep_r))
    else $error("setup changed endpoints");
  a_iso_limit_short: assert property (ctrl2_r[0] |->
    iso_limit_bytes == 11'h0f0)
    else $error("short iso limit wrong");
  a_iso_limit_full: assert property (ctrl2_r[1:0] == 2'b00 |->
    iso_limit_bytes == 11'h3ff)
    else $error("full iso limit wrong");
  a_cmd_rx_only: assert property (wr_epcmd && !cmd_tx |=>
    ep_r[$past(cmd_ep)].tx == $past(ep_r[cmd_ep].tx))
    else $error("receive command touched transmit");
  a_cmd_tx_only: assert property (wr_epcmd && cmd_tx |=>
    ep_r[$past(cmd_ep)].rx == $past(ep_r[cmd_ep].rx))
    else $error("transmit command touched receive");
  a_cmd_handshake: assert property (wr_epcmd && !cmd_code[2] && !cmd_tx |=>
    ep_r[$past(cmd_ep)].rx.hs == uec_hs_t'($past(cmd_code[1:0])))
    else $error("handshake command failed");
  a_cmd_iso_set: assert property (wr_epcmd && cmd_code == 3'h7 && !cmd_tx |=>
    ep_r[$past(cmd_ep)].rx.iso)
    else $error("iso set command failed");
  a_cmd_one_ep: assert property (wr_epcmd |=>
    ep_r[$past(cmd_ep) + 4'h1] == $past(ep_r[cmd_ep + 4'h1]))
    else $error("command touched another endpoint");
  a_setup_answer: assert property (eng_in.setup_seen && !nctl_all[eng_in.endpoint] |->
    !setup_ignore_out)
    else $error("control endpoint ignored setup");
  a_read_idle_zero: assert property (!bus_rd |=>
    bus_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule // uec_engine_ctrl
`default_nettype wire

// ==== uec_defines.svh ====
// Offsets, field positions, reset values and timing counts of the engine control block
`ifndef UEC_DEFINES_SVH
`define UEC_DEFINES_SVH
`define UEC_ADDR_W 16
`define UEC_OFF_CTRL1 16'h7f94
`define UEC_OFF_CONFIG 16'h7f98
`define UEC_OFF_CTRL2 16'h7fa9
`define UEC_OFF_EPCMD 16'h7faa
`define UEC_OFF_NCTL_HI 16'h7fab
`define UEC_OFF_NCTL_LO 16'h7fac
`define UEC_OFF_RSVD 16'h7fad
`define UEC_OFF_FRAME_LO 16'h7f90
`define UEC_OFF_FRAME_HI 16'h7f91
`define UEC_OFF_ENDPOINT_CONTROL_BITS_LO 16'h7fb0
`define UEC_OFF_ENDPOINT_CONTROL_BITS_HI 16'h7fbf
`define UEC_RST_CONFIG 8'h40
`define UEC_RST_ZERO 8'h00
`define UEC_CFG_FULL_SPEED_ENABLE 7
`define UEC_CFG_ENG_RST 6
`define UEC_CFG_FRM_RST 5
`define UEC_CFG_EXTFRM 4
`define UEC_CFG_SUSP 3
`define UEC_CFG_RESUME 2
`define UEC_CTRL2_BUSY 2
`define UEC_EPC_TX_BIT 7
`define UEC_EPC_BUS_RST_NS 2667
`define UEC_CLK_NS 25
`define UEC_BUS_RST_CYC ((`UEC_EPC_BUS_RST_NS + `UEC_CLK_NS - 1) / `UEC_CLK_NS)
`define UEC_ISO_1023 11'h3ff
`define UEC_ISO_240 11'h0f0
`define UEC_ISO_496 11'h1f0
`endif

// ==== uec_pkg.sv ====
// Types shared by the engine control block
`default_nettype none
package uec_pkg;
  typedef enum logic [1:0] {UEC_HS_OFF, UEC_HS_STALL, UEC_HS_NORMAL, UEC_HS_NAK} uec_hs_t;
  typedef struct packed {
    logic iso;
    uec_hs_t hs;
    logic toggle;
  } uec_dir_t;
  typedef struct packed {
    uec_dir_t tx;
    uec_dir_t rx;
  } uec_ep_t;
  typedef struct packed {
    logic dma_inhibit;
    logic force_ack;
    logic force_last_tag;
    logic force_overflow;
    logic force_abort;
    logic force_end_of_transaction;
  } uec_force_t;
  typedef struct packed {
    logic setup_seen;
    logic [3:0] endpoint;
    logic resume_seen;
    logic se0;
    logic frame_load;
    logic [10:0] frame_value;
    logic frame_missed;
    logic rx_last_tag;
    logic tx_success;
  } uec_eng_t;
endpackage : uec_pkg
`default_nettype wire

// ==== uec_engine_model.sv ====
// Engine side model feeding status levels and setup pulses to the control block
`default_nettype none
module uec_engine_model
  import uec_pkg::*;
(
  input wire logic clk,
  output var uec_eng_t eng
);
  timeunit 1ns;
  timeprecision 1ps;
  initial eng = '0;
  // Endpoint number is only valid beside the pulse, so it turns to garbage after
  task automatic setup_on(input logic [3:0] ep);
    eng.setup_seen <= 1'b1;
    eng.endpoint <= ep;
  endtask
  task automatic setup_off();
    eng.setup_seen <= 1'b0;
    eng.endpoint <= ~eng.endpoint;
  endtask
  task automatic frame_step(input logic ld, input logic miss, input logic [10:0] v);
    eng.frame_load <= ld;
    eng.frame_missed <= miss;
    eng.frame_value <= v;
  endtask
  // Line and FIFO levels, held until changed
  task automatic levels(input logic se0, input logic res, input logic tag, input logic ok);
    eng.se0 <= se0;
    eng.resume_seen <= res;
    eng.rx_last_tag <= tag;
    eng.tx_success <= ok;
  endtask
endmodule // uec_engine_model
`default_nettype wire

// ==== test_usb_engine_control_endpoint_cmd.sv ====
// Self-checking bench of the engine control block
`include "uec_defines.svh"
`default_nettype none
module test_usb_engine_control_endpoint_cmd
  import uec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
  logic clk = 0, nrst = 0, bus_wr = 0, bus_rd = 0, rd_v = 0;
  logic [15:0] bus_addr = '0;
  logic [7:0] bus_wdata = '0, bus_rdata, cmd, epm [16];
  uec_eng_t eng_in;
  uec_force_t force_out;
  logic engine_reset_out, engine_suspend_out, engine_send_resume_out;
  logic full_speed_enable_out, setup_ignore_out, resume_irq, bus_reset_irq;
  logic [10:0] iso_limit_bytes;
  logic [10:0] lim [4] = '{11'h3ff, 11'h0f0, 11'h1f0, 11'h0f0};
  uec_ep_t [15:0] ep_ctrl_out;
  int miscompares = 0, checked = 0, cycles = 0, n_res = 0, n_br = 0, n_er = 0;
  logic [23:0] exp_q [$];
  logic [23:0] e;
  initial forever #12.5 clk = ~clk;
  uec_engine_ctrl #(.EP_NUM(16)) uec_engine_ctrl_i (.clk, .nrst, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .eng_in, .force_out, .engine_reset_out,
    .engine_suspend_out, .engine_send_resume_out, .full_speed_enable_out,
    .setup_ignore_out, .iso_limit_bytes, .ep_ctrl_out, .resume_irq, .bus_reset_irq);
  uec_engine_model uec_engine_model_i (.clk(clk), .eng(eng_in));
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    rd_v <= bus_rd;
    cycles++;
    n_res += int'(resume_irq);
    n_br += int'(bus_reset_irq);
    n_er += int'(engine_reset_out);
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // Read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_v) begin
      e = exp_q.pop_front();
      `CHK($sformatf("rdata@%h", e[23:8]), e[7:0], bus_rdata)
    end
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({a, d});
    bus_addr <= a;
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge clk);
  endtask
  task automatic cyc(input int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic eps();
    for (int i = 0; i < 16; i++) rd(`UEC_OFF_ENDPOINT_CONTROL_BITS_LO + 16'(i), epm[i]);
    cyc(1);
    for (int i = 0; i < 16; i++) `CHK("ep", epm[i], ep_ctrl_out[i])
  endtask
  task automatic sp(input logic [3:0] ep, input logic x);
    cyc(0);
    uec_engine_model_i.setup_on(ep);
    @(negedge clk);
    `CHK("ignore", x, setup_ignore_out)
    @(posedge clk);
    uec_engine_model_i.setup_off();
    @(posedge clk);
  endtask
  function automatic logic [7:0] apply(input logic [7:0] cur, input logic [7:0] c);
    uec_dir_t d;
    d = c[7] ? cur[7:4] : cur[3:0];
    if (!c[6]) d.hs = uec_hs_t'(c[5:4]);
    else if (c[5]) d.iso = c[4];
    else d.toggle = c[4];
    return c[7] ? {d, cur[3:0]} : {cur[7:4], d};
  endfunction
  // Busy forces NAK only where a direction is not disabled
  function automatic logic [7:0] busy(input uec_ep_t p);
    if (p.tx.hs != UEC_HS_OFF) p.tx.hs = UEC_HS_NAK;
    if (p.rx.hs != UEC_HS_OFF) p.rx.hs = UEC_HS_NAK;
    return p;
  endfunction
  initial begin
    logic [1:0] l;
    logic [15:0] m;
    logic [3:0] ep;
    int k;
    void'($urandom(33));
    foreach (epm[i]) epm[i] = 8'h00;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`UEC_OFF_CTRL2, 8'h00);
    rd(`UEC_OFF_EPCMD, 8'h00);
    rd(`UEC_OFF_NCTL_HI, 8'h00);
    rd(`UEC_OFF_NCTL_LO, 8'h00);
    rd(`UEC_OFF_RSVD, 8'h00);
    wr(16'h1234, 8'hff);
    rd(16'h1234, 8'h00);
    eps();
    for (int j = 0; j < 6; j++) begin
      l = 2'($urandom);
      uec_engine_model_i.levels(1'b0, 1'b0, l[1], l[0]);
      wr(`UEC_OFF_CTRL1, 8'h04 << j);
      rd(`UEC_OFF_CTRL1, {6'h01 << j, l});
      cyc(1);
      `CHK("force", 6'h01 << j, force_out)
    end
    wr(`UEC_OFF_CTRL1, 8'h00);
    for (int j = 0; j < 4; j++) begin
      wr(`UEC_OFF_CTRL2, 8'(j));
      rd(`UEC_OFF_CTRL2, 8'(j));
      cyc(1);
      `CHK("iso", lim[j], iso_limit_bytes)
    end
    `CHK("force", 6'h00, force_out)
    for (int i = 0; i < 32; i++) begin
      cmd = {i[3:0], 4'($urandom)};
      epm[cmd[3:0]] = apply(epm[cmd[3:0]], cmd);
      wr(`UEC_OFF_EPCMD, cmd);
      rd(`UEC_OFF_ENDPOINT_CONTROL_BITS_LO + 16'(cmd[3:0]), epm[cmd[3:0]]);
    end
    rd(`UEC_OFF_EPCMD, cmd);
    eps();
    m = 16'($urandom);
    wr(`UEC_OFF_NCTL_LO, m[7:0]);
    wr(`UEC_OFF_NCTL_HI, m[15:8]);
    rd(`UEC_OFF_NCTL_LO, m[7:0]);
    rd(`UEC_OFF_NCTL_HI, m[15:8]);
    for (int i = 0; i < 16; i++) sp(4'(i), m[i]);
    eps();
    wr(`UEC_OFF_NCTL_LO, 8'h00);
    wr(`UEC_OFF_NCTL_HI, 8'h00);
    wr(`UEC_OFF_CTRL2, 8'h04);
    for (int i = 0; i < 4; i++) begin
      ep = 4'($urandom);
      sp(ep, 1'b0);
      epm[ep] = busy(epm[ep]);
    end
    eps();
    k = n_res;
    wr(`UEC_OFF_CONFIG, 8'h88);
    uec_engine_model_i.levels(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(4);
    `CHK("suspend", 1'b1, engine_suspend_out)
    uec_engine_model_i.levels(1'b0, 1'b0, 1'b0, 1'b0);
    rd(`UEC_OFF_CONFIG, 8'h8a);
    cyc(2);
    `CHK("resume irq", k + 1, n_res)
    wr(`UEC_OFF_CONFIG, 8'h84);
    cyc(1);
    rd(`UEC_OFF_CONFIG, 8'h84);
    cyc(1);
    `CHK("resume", 1'b1, engine_send_resume_out)
    k = n_er;
    wr(`UEC_OFF_CONFIG, 8'hc0);
    cyc(3);
    `CHK("engine reset", k + 1, n_er)
    `CHK("full speed", 1'b1, full_speed_enable_out)
    k = n_br;
    uec_engine_model_i.levels(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(100);
    `CHK("early bus reset", k, n_br)
    cyc(14);
    `CHK("bus reset", k + 1, n_br)
    rd(`UEC_OFF_CONFIG, 8'h81);
    uec_engine_model_i.levels(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(3);
    rd(`UEC_OFF_CONFIG, 8'h80);
    wr(`UEC_OFF_CONFIG, 8'h90);
    uec_engine_model_i.frame_step(1'b1, 1'b0, 11'h7ff);
    cyc(1);
    uec_engine_model_i.frame_step(1'b0, 1'b1, 11'h000);
    cyc(1);
    uec_engine_model_i.frame_step(1'b0, 1'b0, 11'h000);
    rd(`UEC_OFF_FRAME_LO, 8'h00);
    rd(`UEC_OFF_FRAME_HI, 8'h08);
    uec_engine_model_i.frame_step(1'b1, 1'b0, 11'h345);
    cyc(1);
    uec_engine_model_i.frame_step(1'b0, 1'b0, 11'h000);
    rd(`UEC_OFF_FRAME_LO, 8'h45);
    rd(`UEC_OFF_FRAME_HI, 8'h0b);
    wr(`UEC_OFF_CONFIG, 8'hb0);
    rd(`UEC_OFF_FRAME_LO, 8'h00);
    rd(`UEC_OFF_FRAME_HI, 8'h08);
    wr(`UEC_OFF_CONFIG, 8'h80);
    cyc(1);
    rd(`UEC_OFF_FRAME_HI, 8'h00);
    cyc(4);
    end_of_test();
  end
endmodule // test_usb_engine_control_endpoint_cmd
`default_nettype wire
